// file: pkg/io_map_consts.svh
// address map, reset values, bit positions and timing counts of the io bank
// assumes a 10 MHz system clock and 8-bit data memory addresses
`ifndef IO_MAP_CONSTS_SVH
`define IO_MAP_CONSTS_SVH
`define A_KEY        8'he0
`define A_TDATA      8'he4
`define A_KMASK      8'he8
`define A_TMASK      8'heb
`define A_KFLAG      8'hed
`define A_TFLAG      8'hef
`define A_OUTC       8'hf3
`define A_PDATA      8'hf6
`define A_TCLR       8'hf9
`define A_HLOAD      8'hfa
`define A_LCD        8'hfb
`define A_PDIR       8'hfc
`define RAM_WORDS    8'h50
`define DISP_LO      8'h90
`define DISP_HI      8'haf
`define RESET_PAGE   4'h1
`define RESET_STEP   8'h00
`define VEC_PAGE     4'h1
`define VEC_TIMER    8'h01
`define VEC_KEY      8'h04
`define VEC_BOTH     8'h05
`define ENTRY_LAST   4'hb
`define STACK_WORDS  8'h03
`define TCLR_BIT     2
`define HLOAD_BIT    3
`define LCD_BIT      3
`define TM32_BIT     2
`define TM8_BIT      4
`define TM2_BIT      6
`define CLK_PERIOD_NS   100
`define TICK_PERIOD_NS  3906250
`define TICK_CYCLES  (`TICK_PERIOD_NS / `CLK_PERIOD_NS)
`endif

// file: pkg/io_map_pkg.sv
// types shared by the io bank and its bench
// assumes nothing beyond the constants header
package io_map_pkg;
   typedef logic [3:0] nibble_t;
   typedef logic [7:0] addr_t;
   typedef enum logic {ENTRY_IDLE, ENTRY_RUN} entry_state_t;
endpackage : io_map_pkg

// file: src/io_map_bank.sv
// peripheral register bank, data memory, program store and interrupt entry
// assumes the cpu core drives the memory port and pc controls on the same clock
//
// Notes on behaviour
// - interrupt entry starts only once the running instruction has finished
// - first entry step pushes the current program counter onto the ram stack
// - then the pc is loaded with the vector of the requesting source
// - push plus vector load take exactly twelve system clock cycles
// - reset at step 00, timer 01, key 04, key with timer 05
// - each entry uses three nibbles of stack space
// - words 000 to 00f also reached through the memory register pointer
// - program store is a 1024 step rom of 12-bit words
// - ram holds 80 data words and 32 display words
// - key input word reads the four pin levels, reset to zero
// - timer data word shows 16, 8, 4 and 2 hz stages on bits 0..3
// - one read/write enable bit per key pin, reset to masked
// - timer enables for 2, 8, 32 hz on bits 2..0, bit 3 reads zero
// - key interrupt flag at bit 0 of 0ed clears after being read
// - timer flags for 2, 8, 32 hz on bits 2..0 clear after read
// - unassigned bits always read zero
// - output word 0f3 holds buzzer and frequency enables, reset off
// - those bits are also the two output pin latches, bits 3:2 read zero
// - bit 0 of 0fc sets bidirectional port direction, reset input
// - heavy load bit 3 selects protection mode, reset normal
// - reset puts the program counter at page 1 step 00
`timescale 1ns/1ps
`include "io_map_consts.svh"

module io_map_bank #(
   parameter int TICK_CYCLES = `TICK_CYCLES
) (
   // clock and reset
   input  wire  logic                clock,
   input  wire  logic                rstn,
   // data memory port from the cpu
   input  wire  io_map_pkg::addr_t   memAddr,
   input  wire  logic                memRd,
   input  wire  logic                memWr,
   input  wire  io_map_pkg::nibble_t memWrData,
   input  wire  logic                mregSel,
   output       io_map_pkg::nibble_t memRdData,
   // cpu sequencing
   input  wire  logic                instrDone,
   input  wire  logic                intEnable,
   input  wire  logic                pcAdvance,
   input  wire  logic                pcJump,
   input  wire  io_map_pkg::nibble_t jumpPage,
   input  wire  io_map_pkg::addr_t   jumpStep,
   input  wire  logic                spLoad,
   input  wire  io_map_pkg::addr_t   spValue,
   input  wire  logic                rpLoad,
   input  wire  io_map_pkg::nibble_t rpValue,
   output       io_map_pkg::nibble_t pcPage,
   output       io_map_pkg::addr_t   pcStep,
   output logic [11:0]               instrWord,
   output logic                      entryBusy,
   output logic                      entryDone,
   // pins
   input  wire  logic [3:0]          keyPin,
   input  wire  logic [3:0]          bidirIn,
   output logic [3:0]                bidirOut,
   output logic [3:0]                bidirOe,
   output logic                      outPinA,
   output logic                      outPinB,
   output logic                      heavyLoad,
   output logic                      lcdStatic
);
   import io_map_pkg::*;

   localparam logic [11:0] ROM_IMAGE [0:1023] = '{default: 12'h000};

   entry_state_t state;
   logic [3:0]   entryCount;
   addr_t        vecStep;
   addr_t        stackPtr;
   nibble_t      memoryRegisterPointer;
   nibble_t      ramMem  [0:79];
   nibble_t      dispMem [0:31];
   logic [3:0]   keyS1, keyS2, keyS3, keyLevel;
   logic [3:0]   pinS1, pinS2, pinS3, pinLevel;
   nibble_t      keyMask;
   logic [2:0]   timerMask;
   logic         keyIrqFlag;
   logic [2:0]   timerFlag;
   logic         bidirDirection;
   nibble_t      bidirLatch;
   logic [15:0]  tickCnt;
   logic [7:0]   tCnt;

   // address decode
   wire addr_t effAddr   = mregSel ? {4'h0, memoryRegisterPointer} : memAddr;
   wire logic  cpuRd     = memRd & ~entryBusy;
   wire logic  cpuWr     = memWr & ~entryBusy;
   wire logic  isRam     = effAddr < `RAM_WORDS;
   wire logic  isDisp    = (effAddr >= `DISP_LO) && (effAddr <= `DISP_HI);
   wire logic  wrIo      = cpuWr;
   wire logic  rdKFlag   = cpuRd && (effAddr == `A_KFLAG);
   wire logic  rdTFlag   = cpuRd && (effAddr == `A_TFLAG);
   wire logic  wrKMask   = wrIo && (effAddr == `A_KMASK);
   wire logic  wrTMask   = wrIo && (effAddr == `A_TMASK);
   wire logic  wrOutC    = wrIo && (effAddr == `A_OUTC);
   wire logic  wrPData   = wrIo && (effAddr == `A_PDATA);
   wire logic  wrHLoad   = wrIo && (effAddr == `A_HLOAD);
   wire logic  wrLcd     = wrIo && (effAddr == `A_LCD);
   wire logic  wrPDir    = wrIo && (effAddr == `A_PDIR);
   wire logic  timerClr  = wrIo && (effAddr == `A_TCLR) && memWrData[`TCLR_BIT];

   // stack push during interrupt entry
   wire logic  pushing   = entryBusy && (entryCount < 4'h3);
   wire addr_t pushAddr  = stackPtr - 8'h01;
   wire nibble_t pushData = (entryCount == 4'h0) ? pcPage :
                            (entryCount == 4'h1) ? pcStep[7:4] : pcStep[3:0];
   wire addr_t wrAddr    = entryBusy ? pushAddr : effAddr;
   wire nibble_t wrData  = entryBusy ? pushData : memWrData;
   wire logic  wrEn      = entryBusy ? pushing : cpuWr;

   // pin filters: a change counts once stages two and three agree
   wire logic [3:0] keyAgree = ~(keyS2 ^ keyS3);
   wire logic [3:0] keyNext  = (keyAgree & keyS3) | (~keyAgree & keyLevel);
   wire logic [3:0] pinAgree = ~(pinS2 ^ pinS3);
   wire logic [3:0] pinNext  = (pinAgree & pinS3) | (~pinAgree & pinLevel);
   wire logic       keyEvent = |(keyNext & ~keyLevel & keyMask);

   // clock timer taps from a 256 hz count
   wire logic       tick     = tickCnt == 16'(TICK_CYCLES - 1);
   wire logic [7:0] tNext    = tCnt + 8'h01;
   wire logic [2:0] tEvent   = {3{tick & ~timerClr}} &
                               {tCnt[`TM2_BIT] & ~tNext[`TM2_BIT],
                                tCnt[`TM8_BIT] & ~tNext[`TM8_BIT],
                                tCnt[`TM32_BIT] & ~tNext[`TM32_BIT]};

   // interrupt request and vector choice
   wire logic  keyReq    = keyIrqFlag;
   wire logic  timerReq  = |(timerFlag & timerMask);
   wire logic  entryGo   = (state == ENTRY_IDLE) && intEnable && instrDone &&
                           (keyReq | timerReq);
   wire addr_t nextVec   = (keyReq && timerReq) ? `VEC_BOTH :
                           keyReq ? `VEC_KEY : `VEC_TIMER;

   // read selection
   wire nibble_t ramRd   = isRam ? ramMem[effAddr[6:0]] : 4'h0;
   wire nibble_t dispRd  = isDisp ? dispMem[effAddr[4:0]] : 4'h0;
   wire nibble_t pData   = bidirDirection ? bidirLatch : pinLevel;
   wire nibble_t ioRd    =
      (effAddr == `A_KEY)   ? keyLevel :
      (effAddr == `A_TDATA) ? tCnt[6:3] :
      (effAddr == `A_KMASK) ? keyMask :
      (effAddr == `A_TMASK) ? {1'b0, timerMask} :
      (effAddr == `A_KFLAG) ? {3'h0, keyIrqFlag} :
      (effAddr == `A_TFLAG) ? {1'b0, timerFlag} :
      (effAddr == `A_OUTC)  ? {2'h0, outPinB, outPinA} :
      (effAddr == `A_PDATA) ? pData :
      (effAddr == `A_HLOAD) ? {heavyLoad, 3'h0} :
      (effAddr == `A_LCD)   ? {lcdStatic, 3'h0} :
      (effAddr == `A_PDIR)  ? {3'h0, bidirDirection} : 4'h0;
   wire nibble_t rdMux   = ramRd | dispRd | ioRd;

   // program store: 4 pages of 256 steps
   wire logic [9:0] romAddr = {pcPage[1:0], pcStep};

   // entry sequencer
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state      <= ENTRY_IDLE;
         entryBusy  <= 1'b0;
         entryDone  <= 1'b0;
         entryCount <= 4'h0;
         vecStep    <= 8'h00;
      end else begin
         entryDone <= 1'b0;
         case (state)
            ENTRY_IDLE: begin
               if (entryGo) begin
                  state      <= ENTRY_RUN;
                  entryBusy  <= 1'b1;
                  entryCount <= 4'h0;
                  vecStep    <= nextVec;
               end
            end
            ENTRY_RUN: begin
               entryCount <= entryCount + 4'h1;
               if (entryCount == `ENTRY_LAST) begin
                  state     <= ENTRY_IDLE;
                  entryBusy <= 1'b0;
                  entryDone <= 1'b1;
               end
            end
            default: begin
               state     <= ENTRY_IDLE;
               entryBusy <= 1'b0;
            end
         endcase
      end
   end

   // program counter
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         pcPage <= `RESET_PAGE;
         pcStep <= `RESET_STEP;
      end else if (entryBusy && entryCount == `ENTRY_LAST) begin
         pcPage <= `VEC_PAGE;
         pcStep <= vecStep;
      end else if (!entryBusy && pcJump) begin
         pcPage <= jumpPage;
         pcStep <= jumpStep;
      end else if (!entryBusy && pcAdvance) begin
         pcStep <= pcStep + 8'h01;
      end
   end

   // stack and register pointers
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         stackPtr              <= 8'h00;
         memoryRegisterPointer <= 4'h0;
      end else begin
         if (pushing)
            stackPtr <= pushAddr;
         else if (spLoad && !entryBusy)
            stackPtr <= spValue;
         if (rpLoad)
            memoryRegisterPointer <= rpValue;
      end
   end

   // data and display memory, no reset
   always_ff @(posedge clock) begin
      if (wrEn && wrAddr < `RAM_WORDS)
         ramMem[wrAddr[6:0]] <= wrData;
      if (wrEn && wrAddr >= `DISP_LO && wrAddr <= `DISP_HI)
         dispMem[wrAddr[4:0]] <= wrData;
   end

   // pin synchronisers and read data
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         {keyS1, keyS2, keyS3, keyLevel} <= 16'h0000;
         {pinS1, pinS2, pinS3, pinLevel} <= 16'h0000;
         memRdData <= 4'h0;
         instrWord <= 12'h000;
      end else begin
         keyS1     <= keyPin;
         keyS2     <= keyS1;
         keyS3     <= keyS2;
         keyLevel  <= keyNext;
         pinS1     <= bidirIn;
         pinS2     <= pinS1;
         pinS3     <= pinS2;
         pinLevel  <= pinNext;
         memRdData <= cpuRd ? rdMux : 4'h0;
         instrWord <= ROM_IMAGE[romAddr];
      end
   end

   // clock timer
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         tickCnt <= 16'h0000;
         tCnt    <= 8'h00;
      end else if (timerClr) begin
         tickCnt <= 16'h0000;
         tCnt    <= 8'h00;
      end else begin
         tickCnt <= tick ? 16'h0000 : tickCnt + 16'h0001;
         if (tick)
            tCnt <= tNext;
      end
   end

   // interrupt masks and factor flags; a new event beats the read clear
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         keyMask    <= 4'h0;
         timerMask  <= 3'h0;
         keyIrqFlag <= 1'b0;
         timerFlag  <= 3'h0;
      end else begin
         if (wrKMask)
            keyMask <= memWrData;
         if (wrTMask)
            timerMask <= memWrData[2:0];
         keyIrqFlag <= (keyIrqFlag & ~rdKFlag) | keyEvent;
         timerFlag  <= (timerFlag & ~{3{rdTFlag}}) | tEvent;
      end
   end

   // output, port and mode controls
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         outPinA        <= 1'b0;
         outPinB        <= 1'b0;
         bidirDirection <= 1'b0;
         bidirLatch     <= 4'h0;
         bidirOut       <= 4'h0;
         bidirOe        <= 4'h0;
         heavyLoad      <= 1'b0;
         lcdStatic      <= 1'b0;
      end else begin
         if (wrOutC) begin
            outPinA <= memWrData[0];
            outPinB <= memWrData[1];
         end
         if (wrPDir)
            bidirDirection <= memWrData[0];
         if (wrPData)
            bidirLatch <= memWrData;
         bidirOut <= wrPData ? memWrData : bidirLatch;
         bidirOe  <= {4{wrPDir ? memWrData[0] : bidirDirection}};
         if (wrHLoad)
            heavyLoad <= memWrData[`HLOAD_BIT];
         if (wrLcd)
            lcdStatic <= memWrData[`LCD_BIT];
      end
   end

   // checks
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rstn);

   entry_start_a: assert property ($rose(entryBusy) |-> $past(instrDone))
      else $error("entry began before the instruction finished");
   push_page_a: assert property ($rose(entryBusy) |-> wrEn && wrData == pcPage)
      else $error("first push is not the pc page");
   vector_load_a: assert property (entryDone |-> pcStep == vecStep && pcPage == 4'h1)
      else $error("pc not loaded with the vector");
   entry_length_a: assert property ($rose(entryBusy) |-> entryBusy[*8] ##1
                                     entryBusy[*4] ##1 entryDone)
      else $error("entry did not take twelve cycles");
   vector_both_a: assert property (entryGo && keyReq && timerReq |=> vecStep == 8'h05)
      else $error("joint request vector wrong");
   stack_words_a: assert property ($rose(entryBusy) |-> ##3
                                    stackPtr == $past(stackPtr, 3) - 8'h03)
      else $error("entry did not use three stack words");
   timer_data_a: assert property (cpuRd && effAddr == 8'he4 |=>
                                   memRdData == $past(tCnt[6:3]))
      else $error("timer data word wrong");
   key_clear_a: assert property (rdKFlag && !keyEvent |=> !keyIrqFlag)
      else $error("key flag survived its read");
   tmask_zero_a: assert property (cpuRd && effAddr == 8'heb |=> !memRdData[3])
      else $error("unused mask bit read as one");
   dir_drive_a: assert property (wrPDir |=> bidirOe == {4{$past(memWrData[0])}})
      else $error("port direction not applied");
   key_level_a: assert property (cpuRd && effAddr == `A_KEY |=>
                                  memRdData == $past(keyLevel))
      else $error("key level read wrong");
   outc_zero_a: assert property (cpuRd && effAddr == `A_OUTC |=>
                                  memRdData[3:2] == 2'h0)
      else $error("unused output control bits read as one");
   tclr_zero_a: assert property (cpuRd && effAddr == `A_TCLR |=>
                                  memRdData == 4'h0)
      else $error("timer clear word read not zero");
   hload_zero_a: assert property (cpuRd && effAddr == `A_HLOAD |=>
                                   memRdData[2:0] == 3'h0)
      else $error("unused heavy load bits read as one");
   kflag_zero_a: assert property (cpuRd && effAddr == `A_KFLAG |=>
                                   memRdData[3:1] == 3'h0)
      else $error("unused key flag bits read as one");
   key_set_a: assert property (keyEvent |=> keyIrqFlag)
      else $error("key event did not set its flag");
   timer_set_a: assert property (|tEvent |=>
                                  (timerFlag & $past(tEvent)) == $past(tEvent))
      else $error("timer event did not set its flag");
   timer_clear_a: assert property (timerClr |=> tCnt == 8'h00)
      else $error("timer clear did not clear the count");
   pc_hold_a: assert property (entryBusy && entryCount != `ENTRY_LAST |=>
                                $stable(pcStep) && $stable(pcPage))
      else $error("pc moved before the vector load");

   entry_seen_c: cover property ($rose(entryBusy) ##12 entryDone);
   both_vec_c: cover property (entryGo && keyReq && timerReq);
   key_entry_c: cover property (entryGo && keyReq && !timerReq);
   key_flag_c: cover property (keyEvent ##[1:20] rdKFlag);
   timer_flag_c: cover property (|tEvent);

endmodule : io_map_bank

// file: tb/cpu_model.sv
// cpu side of the io bank memory port: word read and write cycles
// assumes the bank samples on the rising edge; this model drives at the falling edge
`timescale 1ns/1ps
module cpu_model (
   // clock
   input  wire logic                clock,
   // memory port
   output io_map_pkg::addr_t        memAddr,
   output logic                     memRd,
   output logic                     memWr,
   output io_map_pkg::nibble_t      memWrData,
   output logic                     mregSel,
   input  wire io_map_pkg::nibble_t memRdData
);
   import io_map_pkg::*;
   initial begin
      memAddr   = 8'h00;
      memRd     = 1'b0;
      memWr     = 1'b0;
      memWrData = 4'h0;
      mregSel   = 1'b0;
   end
   // one strobe cycle, data taken one edge later
   task automatic rd(input addr_t a, output nibble_t d);
      @(negedge clock);
      memAddr = a;
      memRd   = 1'b1;
      @(negedge clock);
      memRd   = 1'b0;
      memAddr = ~a;
      d       = memRdData;
   endtask : rd
   // released lines show the inverse so a stale value never looks valid
   task automatic wr(input addr_t a, input nibble_t d, input logic sel);
      @(negedge clock);
      memAddr   = a;
      memWrData = d;
      mregSel   = sel;
      memWr     = 1'b1;
      @(negedge clock);
      memWr     = 1'b0;
      mregSel   = 1'b0;
      memAddr   = ~a;
      memWrData = ~d;
   endtask : wr
endmodule : cpu_model

// file: tb/testbench.sv
// self-checking bench of the io bank with a cpu model on its memory port
// assumes the constants header is on the include path and TICK_CYCLES is shortened
`timescale 1ns/1ps
`include "io_map_consts.svh"
module testbench;
   import io_map_pkg::*;
   typedef struct {addr_t a; nibble_t w; nibble_t e;} row_t;
   logic        clock = 1'b0;
   logic        rstn = 1'b0;
   logic        instrDone = 1'b0;
   logic        intEnable = 1'b0;
   logic        pcAdvance = 1'b0;
   logic        pcJump = 1'b0;
   logic        spLoad = 1'b0;
   logic        rpLoad = 1'b0;
   nibble_t     jumpPage = 4'h0;
   addr_t       jumpStep = 8'h00;
   addr_t       spValue = 8'h00;
   nibble_t     rpValue = 4'h0;
   logic [3:0]  keyPin = 4'h0;
   logic [3:0]  bidirIn = 4'h0;
   addr_t       memAddr, pcStep;
   logic        memRd, memWr, mregSel, entryBusy, entryDone;
   logic        outPinA, outPinB, heavyLoad, lcdStatic;
   nibble_t     memWrData, memRdData, pcPage, d;
   logic [11:0] instrWord;
   logic [3:0]  bidirOut, bidirOe;
   int          err_count = 0;
   int          n_compared = 0;
   row_t rows [0:9] = '{'{`A_KMASK, 4'hf, 4'hf}, '{`A_TMASK, 4'hf, 4'h7},
      '{`A_OUTC, 4'hf, 4'h3}, '{`A_HLOAD, 4'hf, 4'h8}, '{`A_LCD, 4'hf, 4'h8},
      '{`A_PDIR, 4'hf, 4'h1}, '{`A_TCLR, 4'hf, 4'h0}, '{8'h10, 4'h5, 4'h5},
      '{8'h9f, 4'ha, 4'ha}, '{8'hc0, 4'h5, 4'h0}};
   always #50 clock = ~clock;
   cpu_model cpu_u (.clock(clock), .memAddr(memAddr), .memRd(memRd), .memWr(memWr),
      .memWrData(memWrData), .mregSel(mregSel), .memRdData(memRdData));
   io_map_bank #(.TICK_CYCLES(4)) dut_u (.clock(clock), .rstn(rstn), .memAddr(memAddr),
      .memRd(memRd), .memWr(memWr), .memWrData(memWrData), .mregSel(mregSel),
      .memRdData(memRdData), .instrDone(instrDone), .intEnable(intEnable),
      .pcAdvance(pcAdvance), .pcJump(pcJump), .jumpPage(jumpPage), .jumpStep(jumpStep),
      .spLoad(spLoad), .spValue(spValue), .rpLoad(rpLoad), .rpValue(rpValue),
      .pcPage(pcPage), .pcStep(pcStep), .instrWord(instrWord), .entryBusy(entryBusy),
      .entryDone(entryDone), .keyPin(keyPin), .bidirIn(bidirIn), .bidirOut(bidirOut),
      .bidirOe(bidirOe), .outPinA(outPinA), .outPinB(outPinB), .heavyLoad(heavyLoad),
      .lcdStatic(lcdStatic));
   task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic conclude;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : conclude
   task automatic keyRise(input int settle);
      keyPin = 4'h0;
      repeat (6) @(negedge clock);
      keyPin = 4'h1;
      repeat (settle) @(negedge clock);
   endtask : keyRise
   task automatic entry(input addr_t v);
      int n;
      n = 0;
      intEnable = 1'b1;
      instrDone = 1'b1;
      while (entryBusy !== 1'b1 && n < 200) begin
         @(negedge clock);
         n++;
      end
      instrDone = 1'b0;
      intEnable = 1'b0;
      n = 0;
      while (entryBusy === 1'b1 && n < 50) begin
         @(negedge clock);
         n++;
      end
      chk(12'(n), 12'h00c);
      chk(entryDone, 1'b1);
      chk({pcPage, pcStep}, {`VEC_PAGE, v});
      $display("entry test done");
   endtask : entry
   initial begin
      #(6000 * `CLK_PERIOD_NS);
      err_count++;
      conclude();
   end
   initial begin
      repeat (2) @(negedge clock);
      rstn = 1'b1;
      chk({pcPage, pcStep}, {`RESET_PAGE, `RESET_STEP});
      cpu_u.rd(`A_KFLAG, d);
      chk(d, 4'h0);
      cpu_u.rd(`A_TFLAG, d);
      chk(d, 4'h0);
      // memories have no reset value, so only register rows and the unmapped 0c0 row are checked here
      foreach (rows[i]) begin
         cpu_u.rd(rows[i].a, d);
         if (rows[i].a >= `A_KEY || rows[i].a == 8'hc0) begin
            chk(d, 4'h0);
         end
      end
      $display("reset test done");
      keyPin  = 4'ha;
      bidirIn = 4'h6;
      repeat (6) @(negedge clock);
      cpu_u.rd(`A_KEY, d);
      chk(d, 4'ha);
      cpu_u.rd(`A_PDATA, d);
      chk(d, 4'h6);
      chk(bidirOe, 4'h0);
      foreach (rows[i]) begin
         cpu_u.wr(rows[i].a, rows[i].w, 1'b0);
         cpu_u.rd(rows[i].a, d);
         chk(d, rows[i].e);
      end
      chk({outPinB, outPinA, heavyLoad, lcdStatic, bidirOe}, 8'hff);
      cpu_u.wr(`A_PDATA, 4'h9, 1'b0);
      chk(bidirOut, 4'h9);
      $display("register test done");
      @(negedge clock);
      rpValue = 4'h5;
      rpLoad  = 1'b1;
      @(negedge clock);
      rpLoad = 1'b0;
      cpu_u.wr(8'hc0, 4'h6, 1'b1);
      cpu_u.rd(8'h05, d);
      chk(d, 4'h6);
      keyRise(6);
      cpu_u.rd(`A_KFLAG, d);
      chk(d, 4'h1);
      cpu_u.rd(`A_KFLAG, d);
      chk(d, 4'h0);
      cpu_u.wr(`A_TCLR, 4'h4, 1'b0);
      cpu_u.rd(`A_TDATA, d);
      chk(d, 4'h0);
      repeat (720) @(negedge clock);
      cpu_u.rd(`A_TFLAG, d);
      chk(d, 4'h7);
      cpu_u.rd(`A_TFLAG, d);
      chk(d, 4'h0);
      cpu_u.rd(`A_TDATA, d);
      chk(d, 4'h6);
      $display("flag test done");
      jumpPage = 4'h1;
      jumpStep = 8'h22;
      pcJump   = 1'b1;
      @(negedge clock);
      pcJump    = 1'b0;
      pcAdvance = 1'b1;
      spValue   = 8'h40;
      spLoad    = 1'b1;
      intEnable = 1'b1;
      @(negedge clock);
      pcAdvance = 1'b0;
      spLoad    = 1'b0;
      repeat (60) @(negedge clock);
      chk(entryBusy, 1'b0);
      chk(pcStep, 8'h23);
      chk(instrWord, 12'h000);
      entry(`VEC_TIMER);
      cpu_u.rd(8'h3f, d);
      chk(d, 4'h1);
      cpu_u.rd(8'h3e, d);
      chk(d, 4'h2);
      cpu_u.rd(8'h3d, d);
      chk(d, 4'h3);
      cpu_u.wr(`A_TMASK, 4'h0, 1'b0);
      keyRise(6);
      entry(`VEC_KEY);
      cpu_u.rd(`A_KFLAG, d);
      chk(d, 4'h1);
      cpu_u.wr(`A_TMASK, 4'h7, 1'b0);
      keyRise(40);
      entry(`VEC_BOTH);
      @(negedge clock);
      rstn = 1'b0;
      @(negedge clock);
      chk({pcPage, pcStep}, {`RESET_PAGE, `RESET_STEP});
      chk({outPinB, outPinA, heavyLoad, lcdStatic, bidirOe}, 8'h00);
      rstn = 1'b1;
      cpu_u.rd(`A_TMASK, d);
      chk(d, 4'h0);
      $display("mid-run reset test done");
      conclude();
   end
endmodule : testbench
